/* File: pngpm_pkg.sv */
// What this block does
// - direction bit 1 output, 0 input
// - modes 1/2 hold pin 6 direction at 1
// - direction register write-only, reads all ones
// - reset loads direction 40 (modes 1/2), 00
// - software standby keeps direction contents
// - output-direction bits read latch, except pin 6
// - input-direction bits read live pin level
// - data bit 6 reads pin 6 always
// - reset and hardware standby clear whole latch; software standby keeps
// - pin 7: wait, else i2c data, else gpio
// - pin 6 system clock out per mode
// - modes 1/2 pins 5,4,3 bus strobes
// - pin 2 gpio, feeds interrupt 0 if enabled
// - pin 1 host write strobe when slave-selected
// - pin 1 feeds interrupt 1 if enabled
// - slave-pin select affects only pins 1, 0
// - pin 0 host chip-select when slave-selected
// - pin 0 feeds interrupt 2, trigger unless chip-select
package pngpm_pkg;
  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] PNGPM_DIR_IDX = 16'hFFC0;
  localparam logic [15:0] PNGPM_DATA_IDX = 16'hFFC1;
  localparam logic [15:0] PNGPM_CTRL_IDX = 16'hFFC2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PNGPM_DIR_RST_EXP = 8'h40;
  localparam logic [7:0] PNGPM_DIR_RST_SGL = 8'h00;
  localparam logic [7:0] PNGPM_DATA_RST = 8'h00;
  localparam logic [7:0] PNGPM_CTRL_RST = 8'h00;
  localparam logic [7:0] PNGPM_DIR_READ = 8'hFF;
  // ----------------------------------------------------------------
  // pin and control field positions
  // ----------------------------------------------------------------
  localparam int PNGPM_PIN_CLK = 6;
  localparam int PNGPM_CTL_WAIT = 0;
  localparam int PNGPM_CTL_I2C = 1;
  localparam int PNGPM_CTL_SLV_SEL = 2;
  localparam int PNGPM_CTL_INT0 = 3;
  localparam int PNGPM_CTL_INT1 = 4;
  localparam int PNGPM_CTL_INT2 = 5;
  localparam int PNGPM_CTL_TRG = 6;
endpackage

/* File: pngpm_sync.sv */
`timescale 1ns/1ns
module pngpm_sync
  import pngpm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // ----------------------------------------------------------------
  // two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

/* File: pngpm_pin_cell.sv */
`timescale 1ns/1ns
module pngpm_pin_cell
  import pngpm_pkg::*;
(
  input wire logic gp_sel,
  input wire logic dir,
  input wire logic latch,
  input wire logic alt_oe,
  input wire logic alt_val,
  output logic nxt_out,
  output logic nxt_oe
);
  // ----------------------------------------------------------------
  // gpio or alternate drive
  // ----------------------------------------------------------------
  assign nxt_oe = gp_sel ? dir : alt_oe;
  assign nxt_out = gp_sel ? latch : alt_val;
endmodule

/* File: pngpm_top.sv */
`timescale 1ns/1ns
module pngpm_top
  import pngpm_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_expanded,
  input wire logic slave_mode,
  input wire logic hw_standby,
  input wire logic sys_clock_level,
  input wire logic addr_strobe_out,
  input wire logic wr_strobe_n,
  input wire logic rd_strobe_n,
  input wire logic i2c_sda_drive_low,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic wait_n,
  output logic i2c_sda_in,
  output logic ext_int_0,
  output logic ext_int_1,
  output logic ext_int_2,
  output logic converter_ext_trigger,
  output logic host_write_strobe_in,
  output logic host_chip_select_in
);
  if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_addr_w
    $error("pngpm_top: ADDR_W must be 18 to 32");
  end

  logic [7:0] port_direction_ff;
  logic [7:0] port_data_latch_ff;
  logic [7:0] ctrl_ff;
  logic init_pending_ff;
  logic [7:0] pin_s;
  logic [7:0] pin_out_ff;
  logic [7:0] pin_oe_ff;
  logic [7:0] nxt_pin_out;
  logic [7:0] nxt_pin_oe;
  logic [7:0] gp_sel;
  logic [7:0] alt_oe;
  logic [7:0] alt_val;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [7:0] side_ff;
  logic [15:0] reg_idx;
  logic addr_ok;
  logic hit_dir;
  logic hit_data;
  logic hit_ctrl;
  logic setup;
  logic wr_done;
  logic host_pins;
  logic wait_used;
  logic [7:0] data_read;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  pngpm_sync #(.WIDTH(8)) u_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in(pin_in),
    .sync_out(pin_s)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign reg_idx = paddr[17:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && ((paddr >> 18) == '0);
  assign hit_dir = addr_ok && (reg_idx == PNGPM_DIR_IDX);
  assign hit_data = addr_ok && (reg_idx == PNGPM_DATA_IDX);
  assign hit_ctrl = addr_ok && (reg_idx == PNGPM_CTRL_IDX);
  assign setup = psel && !penable && !init_pending_ff;
  assign wr_done = psel && penable && pready_ff && pwrite;
  assign host_pins = slave_mode && ctrl_ff[PNGPM_CTL_SLV_SEL];
  assign wait_used = mode_expanded && ctrl_ff[PNGPM_CTL_WAIT];

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      data_read[i] = port_direction_ff[i] ? port_data_latch_ff[i] : pin_s[i];
    end
    data_read[PNGPM_PIN_CLK] = pin_s[PNGPM_PIN_CLK];
  end

  // ----------------------------------------------------------------
  // apb answer, one wait-free access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !(hit_dir || hit_data || hit_ctrl);
      if (setup) begin
        prdata_ff <= 32'h0000_0000;
        if (!pwrite && hit_dir) begin
          prdata_ff[7:0] <= PNGPM_DIR_READ;
        end else if (!pwrite && hit_data) begin
          prdata_ff[7:0] <= data_read;
        end else if (!pwrite && hit_ctrl) begin
          prdata_ff[7:0] <= ctrl_ff;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // initialisation after reset release or hardware standby
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      init_pending_ff <= 1'b1;
    end else begin
      init_pending_ff <= hw_standby;
    end
  end

  // ----------------------------------------------------------------
  // direction register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      port_direction_ff <= PNGPM_DIR_RST_SGL;
    end else if (init_pending_ff || hw_standby) begin
      port_direction_ff <= mode_expanded ? PNGPM_DIR_RST_EXP : PNGPM_DIR_RST_SGL;
    end else if (wr_done && hit_dir) begin
      port_direction_ff <= pwdata[7:0];
      if (mode_expanded) begin
        port_direction_ff[PNGPM_PIN_CLK] <= 1'b1;
      end
    end else if (mode_expanded) begin
      port_direction_ff[PNGPM_PIN_CLK] <= 1'b1;
    end
    // otherwise held, also through software standby
  end

  // ----------------------------------------------------------------
  // data latch, bit 6 never stored
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      port_data_latch_ff <= PNGPM_DATA_RST;
    end else if (hw_standby) begin
      port_data_latch_ff <= PNGPM_DATA_RST;
    end else if (wr_done && hit_data) begin
      port_data_latch_ff <= pwdata[7:0] & ~(8'h01 << PNGPM_PIN_CLK);
    end
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= PNGPM_CTRL_RST;
    end else if (hw_standby) begin
      ctrl_ff <= PNGPM_CTRL_RST;
    end else if (wr_done && hit_ctrl) begin
      ctrl_ff <= {1'b0, pwdata[6:0]};
    end
  end

  // ----------------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------------
  always_comb begin
    gp_sel = 8'hFF;
    alt_oe = 8'h00;
    alt_val = 8'h00;
    if (wait_used) begin
      gp_sel[7] = 1'b0;
    end else if (ctrl_ff[PNGPM_CTL_I2C]) begin
      gp_sel[7] = 1'b0;
      alt_oe[7] = i2c_sda_drive_low;
    end
    gp_sel[6] = 1'b0;
    alt_oe[6] = port_direction_ff[6];
    alt_val[6] = sys_clock_level;
    if (mode_expanded) begin
      gp_sel[5:3] = 3'h0;
      alt_oe[5:3] = 3'h7;
      alt_val[5:3] = {addr_strobe_out, wr_strobe_n, rd_strobe_n};
    end
    if (host_pins) begin
      gp_sel[1:0] = 2'h0;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_pin
    pngpm_pin_cell u_cell (
      .gp_sel(gp_sel[g]),
      .dir(port_direction_ff[g]),
      .latch(port_data_latch_ff[g]),
      .alt_oe(alt_oe[g]),
      .alt_val(alt_val[g]),
      .nxt_out(nxt_pin_out[g]),
      .nxt_oe(nxt_pin_oe[g])
    );
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_out_ff <= 8'h00;
      pin_oe_ff <= 8'h00;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  // ----------------------------------------------------------------
  // inputs routed to peripherals, active low, idle high except i2c data, which always follows pin 7
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      side_ff <= 8'hFF;
    end else begin
      side_ff[0] <= wait_used ? pin_s[7] : 1'b1;
      side_ff[1] <= pin_s[7];
      side_ff[2] <= ctrl_ff[PNGPM_CTL_INT0] ? pin_s[2] : 1'b1;
      side_ff[3] <= ctrl_ff[PNGPM_CTL_INT1] ? pin_s[1] : 1'b1;
      side_ff[4] <= ctrl_ff[PNGPM_CTL_INT2] ? pin_s[0] : 1'b1;
      side_ff[5] <= (ctrl_ff[PNGPM_CTL_TRG] && !host_pins) ? pin_s[0] : 1'b1;
      side_ff[6] <= host_pins ? pin_s[1] : 1'b1;
      side_ff[7] <= host_pins ? pin_s[0] : 1'b1;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign wait_n = side_ff[0];
  assign i2c_sda_in = side_ff[1];
  assign ext_int_0 = side_ff[2];
  assign ext_int_1 = side_ff[3];
  assign ext_int_2 = side_ff[4];
  assign converter_ext_trigger = side_ff[5];
  assign host_write_strobe_in = side_ff[6];
  assign host_chip_select_in = side_ff[7];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence rd_setup_s(logic hit);
    psel && !penable && !pwrite && hit && !init_pending_ff;
  endsequence

  sequence rd_access_s;
    psel && penable && pready;
  endsequence

  ddr6_fixed_a: assert property (
    mode_expanded && !init_pending_ff && !hw_standby |=> port_direction_ff[6])
    else $error("pin 6 direction not held");
  dir_read_ones_a: assert property (
    rd_setup_s(hit_dir) ##1 rd_access_s |-> prdata[7:0] == PNGPM_DIR_READ)
    else $error("direction read not all ones");
  dir_init_a: assert property (
    init_pending_ff && !hw_standby
    |=> port_direction_ff == (mode_expanded ? PNGPM_DIR_RST_EXP : PNGPM_DIR_RST_SGL))
    else $error("bad init");
  dir_hold_a: assert property (
    !mode_expanded && !(wr_done && hit_dir) && !init_pending_ff && !hw_standby
    |=> $stable(port_direction_ff))
    else $error("direction changed");
  bit6_pin_a: assert property (
    rd_setup_s(hit_data) |=> prdata[6] == $past(pin_s[6]))
    else $error("bit 6 not pin level");
  latch_clear_a: assert property (
    hw_standby |=> port_data_latch_ff == PNGPM_DATA_RST)
    else $error("latch not cleared");
  wait_input_a: assert property (
    wait_used ##1 wait_used |=> !pin_oe[7] && wait_n == $past(pin_s[7]))
    else $error("wait pin driven");
  clock_out_a: assert property (
    mode_expanded && port_direction_ff[6] |=> pin_oe[6])
    else $error("clock pin not driven");
  strobe_out_a: assert property (
    mode_expanded |=> pin_oe[5] && pin_out[4] == $past(wr_strobe_n))
    else $error("strobe not driven");
  int0_feed_a: assert property (
    ctrl_ff[PNGPM_CTL_INT0] |=> ext_int_0 == $past(pin_s[2]))
    else $error("interrupt 0 not fed");
  host_in_a: assert property (
    host_pins |=> pin_oe[1:0] == 2'h0 && host_write_strobe_in == $past(pin_s[1]))
    else $error("host pins not inputs");
  int1_feed_a: assert property (
    ctrl_ff[PNGPM_CTL_INT1] |=> ext_int_1 == $past(pin_s[1]))
    else $error("interrupt 1 not fed");
  gp_drive_a: assert property (
    !mode_expanded && port_direction_ff[3]
    |=> pin_oe[3] && pin_out[3] == $past(port_data_latch_ff[3]))
    else $error("gpio output wrong");
endmodule

/* File: pngpm_pins.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// pads: port level when driven, outside level otherwise
// ----------------------------------------------------------------
module pngpm_pins (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* File: port_nine_gpio_pin_mux_test.sv */
`timescale 1ns/1ns
module port_nine_gpio_pin_mux_test;
  import pngpm_pkg::*;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic mode_expanded = 1, slave_mode = 0, hw_standby = 0, sys_clock_level = 0;
  logic addr_strobe_out = 1, wr_strobe_n = 1, rd_strobe_n = 1, i2c_sda_drive_low = 0;
  logic [7:0] pin_in, pin_out, pin_oe, ext_level = 8'h00, dir_m, lat_m, wd;
  logic wait_n, i2c_sda_in, ext_int_0, ext_int_1, ext_int_2, converter_ext_trigger;
  logic host_write_strobe_in, host_chip_select_in;
  int bad_count = 0, checks = 0, seed = 31241;
  pngpm_top i_pngpm_top (.clock, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .mode_expanded, .slave_mode, .hw_standby,
    .sys_clock_level, .addr_strobe_out, .wr_strobe_n, .rd_strobe_n, .i2c_sda_drive_low,
    .pin_in, .pin_out, .pin_oe, .wait_n, .i2c_sda_in, .ext_int_0, .ext_int_1,
    .ext_int_2, .converter_ext_trigger, .host_write_strobe_in, .host_chip_select_in);
  pngpm_pins i_pngpm_pins (.pin_out, .pin_oe, .ext_level, .pin_in);
  always #50 clock = ~clock;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task settle;
    repeat (5) @(posedge clock);
  endtask
  task rst(input logic m);
    resetn <= 1'b0;
    mode_expanded <= m;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    dir_m = m ? 8'h40 : 8'h00;
    lat_m = 8'h00;
  endtask
  function logic [7:0] exp_rd();
    logic [7:0] o, l;
    o = lat_m;
    o[6] = sys_clock_level;
    l = (dir_m & o) | (~dir_m & ext_level);
    return (dir_m & lat_m & 8'hBF) | (~(dir_m & 8'hBF) & l);
  endfunction
  task stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    #1000000;
    bad_count++;
    stop_test;
  end
  initial begin
    rst(1'b1);
    apb(1'b0, PNGPM_DIR_IDX, 8'h00);
    chk("dir_rd", rd, 32'hFF);
    {sys_clock_level, addr_strobe_out, wr_strobe_n, rd_strobe_n} <= 4'($random(seed));
    apb(1'b1, PNGPM_DIR_IDX, 8'h00);
    settle;
    chk("oe_m1", pin_oe[6:3], 4'hF);
    chk("out_m1", pin_out[6:3], {sys_clock_level, addr_strobe_out, wr_strobe_n, rd_strobe_n});
    apb(1'b1, PNGPM_CTRL_IDX, 8'h01);
    settle;
    chk("wait0", {pin_oe[7], wait_n}, 2'b00);
    ext_level <= 8'h80;
    settle;
    chk("wait1", wait_n, 1'b1);
    apb(1'b1, PNGPM_CTRL_IDX, 8'h02);
    i2c_sda_drive_low <= 1'b1;
    settle;
    chk("sda_lo", {pin_oe[7], pin_out[7], i2c_sda_in}, 3'b100);
    i2c_sda_drive_low <= 1'b0;
    settle;
    chk("sda_hi", {pin_oe[7], i2c_sda_in}, 2'b01);
    rst(1'b0);
    chk("oe_m3", pin_oe, 8'h00);
    repeat (12) begin
      dir_m = 8'($random(seed));
      wd = 8'($random(seed));
      lat_m = wd & 8'hBF;
      apb(1'b1, PNGPM_DIR_IDX, dir_m);
      apb(1'b1, PNGPM_DATA_IDX, wd);
      ext_level <= 8'($random(seed));
      sys_clock_level <= 1'($random(seed));
      settle;
      apb(1'b0, PNGPM_DATA_IDX, 8'h00);
      chk("data_rd", rd, {24'h000000, exp_rd()});
      chk("oe", pin_oe, dir_m);
      chk("out", pin_out & dir_m & 8'hBF, lat_m & dir_m);
    end
    apb(1'b1, PNGPM_DIR_IDX, 8'h00);
    apb(1'b1, PNGPM_CTRL_IDX, 8'h78);
    ext_level <= 8'h00;
    settle;
    chk("side_lo", {ext_int_0, ext_int_1, ext_int_2, converter_ext_trigger}, 4'h0);
    ext_level <= 8'h07;
    settle;
    chk("side_hi", {ext_int_0, ext_int_1, ext_int_2, converter_ext_trigger}, 4'hF);
    apb(1'b1, PNGPM_CTRL_IDX, 8'h00);
    ext_level <= 8'h00;
    settle;
    chk("side_off", {ext_int_0, ext_int_1, ext_int_2, converter_ext_trigger}, 4'hF);
    slave_mode <= 1'b1;
    apb(1'b1, PNGPM_CTRL_IDX, 8'h44);
    apb(1'b1, PNGPM_DIR_IDX, 8'hFF);
    settle;
    chk("host", {host_write_strobe_in, host_chip_select_in, converter_ext_trigger}, 3'b001);
    chk("oe_slave", pin_oe, 8'hFC);
    hw_standby <= 1'b1;
    settle;
    hw_standby <= 1'b0;
    slave_mode <= 1'b0;
    settle;
    chk("oe_hws", pin_oe, 8'h00);
    dir_m = 8'hFF;
    lat_m = 8'h00;
    apb(1'b1, PNGPM_DIR_IDX, dir_m);
    settle;
    apb(1'b0, PNGPM_DATA_IDX, 8'h00);
    chk("lat_hws", rd, {24'h000000, exp_rd()});
    apb(1'b0, 16'hFFC3, 8'h00);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    stop_test;
  end
endmodule
